// >>> mas_pkg.sv
/*
 Shared types and constants of the motion supervisor: setting ranges and
 defaults, stop styles, motion kinds, state codes and signal bundles.
 Assumes the profile engine and the pin logic use these same bundles.
*/
package mas_pkg;

	typedef logic signed [23:0] mas_pos_t;
	typedef logic [19:0] mas_rate_t;

	localparam logic [22:0] INCH_AMT_MIN = 23'h000001;
	localparam logic [22:0] INCH_AMT_DEF = 23'h000001;
	localparam mas_rate_t RATE_MAX = 20'hf4240;
	localparam mas_rate_t SPEED_MIN = 20'h00001;
	localparam mas_rate_t SPEED_DEF = 20'h003e8;
	localparam mas_rate_t START_MIN = 20'h00000;
	localparam mas_rate_t START_DEF = 20'h001f4;
	localparam mas_rate_t RAMP_MIN = 20'h00001;
	localparam mas_rate_t RAMP_DEF = 20'h003e8;
	localparam logic FLAG_DIS = 1'b0;
	localparam logic FLAG_EN = 1'b1;
	localparam logic ORIGIN_RST = 1'b0;
	localparam logic ALARM_EN_DEF = FLAG_DIS;
	localparam logic RETURN_EN_DEF = FLAG_DIS;

	typedef enum logic [1:0] {
		STOP_IMMED = 2'h0,
		STOP_DECEL = 2'h1
	} mas_stop_e;

	typedef enum logic [1:0] {
		MK_POSN = 2'h0,
		MK_CONT = 2'h1,
		MK_TEST = 2'h2,
		MK_HOME = 2'h3
	} mas_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_INCH = 4'h2,
		ST_RET = 4'h4,
		ST_PRESET = 4'h8
	} mas_state_e;

	typedef struct packed {
		logic inch_fwd;
		logic inch_rev;
		logic stop;
		logic lim_pos;
		logic lim_neg;
		logic preset;
		logic start;
		logic seq_start;
		logic [5:0] direct_sel;
		logic pos_err_clear;
		logic excite;
		logic free_run;
		logic main_power;
	} mas_pins_s;

	typedef struct packed {
		mas_rate_t speed;
		mas_rate_t start_speed;
		mas_rate_t ramp;
	} mas_prof_s;

	typedef struct packed {
		mas_pos_t target;
		logic dir;
		mas_prof_s prof;
		logic ramp_unit;
	} mas_move_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic dir;
		mas_kind_e kind;
		mas_pos_t cmd_pos;
	} mas_motion_s;

	typedef struct packed {
		logic [5:0] entry;
		mas_pos_t pos;
		logic mode_abs;
	} mas_teach_s;

endpackage

// >>> mas_sync.sv
/*
 Two-stage synchroniser for all discrete pins of the supervisor.
 Assumes pins are asynchronous levels with no pulse shorter than two clocks.
*/
`timescale 1ns/10ps
module mas_sync (
	input wire logic clock,
	input wire logic rst,
	input wire mas_pkg::mas_pins_s pins_raw,
	output mas_pkg::mas_pins_s pins_sync
);
	typedef struct packed {
		mas_pkg::mas_pins_s s1;
		mas_pkg::mas_pins_s s2;
	} mas_sync_st_s;

	mas_sync_st_s q;
	mas_sync_st_s d;

	// First stage feeds only the second stage
	always_comb begin
		d = q;
		d.s1 = pins_raw;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pins_sync = q.s2;
endmodule

// >>> mas_ot_check.sv
/*
 Overtravel judge: decides stops for running motion and permission for new
 positioning moves. Purely combinational.
 Assumes limit levels are already synchronised and command position is live.
*/
`timescale 1ns/10ps
module mas_ot_check (
	input wire logic hw_ot_en,
	input wire logic sw_ot_en,
	input wire logic origin,
	input wire logic lim_pos,
	input wire logic lim_neg,
	input wire mas_pkg::mas_pos_t sw_lim_hi,
	input wire mas_pkg::mas_pos_t sw_lim_lo,
	input wire mas_pkg::mas_motion_s motion,
	output logic ot_stop,
	output logic fwd_ok,
	output logic rev_ok
);
	logic hw_pos;
	logic hw_neg;
	logic sw_pos;
	logic sw_neg;
	logic into;
	logic posn;

	// Sensor hits count only when enabled
	assign hw_pos = hw_ot_en && lim_pos;
	assign hw_neg = hw_ot_en && lim_neg;
	assign sw_pos = sw_ot_en && origin && (motion.cmd_pos >= sw_lim_hi);
	assign sw_neg = sw_ot_en && origin && (motion.cmd_pos <= sw_lim_lo);
	assign posn = (motion.kind == mas_pkg::MK_POSN);

	// Motion into a limit stops; a positioning move also stops on either hardware sensor
	assign into = motion.dir ? (hw_pos || sw_pos) : (hw_neg || sw_neg);

	assign ot_stop = motion.busy && (into || (posn && (hw_pos || hw_neg)));
	assign fwd_ok = !(hw_pos || hw_neg) && !sw_pos;
	assign rev_ok = !(hw_pos || hw_neg) && !sw_neg;
endmodule

// >>> mas_supervisor.sv
/*
 Motion supervisor top: inching, teaching capture, automatic return, stop
 and overtravel requests, origin tracking and the incomplete-origin alarm.
 Assumes a profile engine on the same clock takes move_start and stop_req
 pulses and reports busy, a one-cycle done and the command position.
*/
`timescale 1ns/10ps
module mas_supervisor (
	input wire logic clock,
	input wire logic rst,
	input wire mas_pkg::mas_pins_s pins_raw,
	input wire logic stop_cmd,
	input wire logic config_exec,
	input wire logic [22:0] inch_amount,
	input wire mas_pkg::mas_prof_s inch_cfg,
	input wire mas_pkg::mas_prof_s ret_cfg,
	input wire logic ramp_unit,
	input wire logic ret_enable,
	input wire mas_pkg::mas_stop_e stop_action,
	input wire mas_pkg::mas_stop_e ot_action,
	input wire logic hw_ot_en,
	input wire logic sw_ot_en,
	input wire mas_pkg::mas_pos_t sw_lim_hi,
	input wire mas_pkg::mas_pos_t sw_lim_lo,
	input wire logic abs_backup_en,
	input wire logic backup_origin_valid,
	input wire logic origin_alarm_en,
	input wire mas_pkg::mas_pos_t preset_position,
	input wire logic abs_pos_err,
	input wire logic alarm_clear,
	input wire logic other_alarm,
	input wire mas_pkg::mas_motion_s motion,
	input wire logic teach_req,
	input wire logic [5:0] teach_entry,
	output logic ready,
	output logic move_start,
	output mas_pkg::mas_move_s move,
	output logic stop_req,
	output mas_pkg::mas_stop_e stop_style,
	output logic pos_load,
	output mas_pkg::mas_pos_t pos_load_value,
	output logic origin_done,
	output logic origin_alarm,
	output logic abs_err_alarm,
	output logic block_positioning,
	output logic teach_write,
	output mas_pkg::mas_teach_s teach
);
	typedef struct packed {
		mas_pkg::mas_state_e st;
		mas_pkg::mas_pins_s prev;
		logic boot;
		logic origin;
		logic abs_err;
		logic org_alarm;
		logic block_pos;
		logic arm;
		logic stop_sent;
		mas_pkg::mas_pos_t last_pos;
		logic move_start;
		mas_pkg::mas_move_s move;
		logic stop_req;
		mas_pkg::mas_stop_e stop_style;
		logic pos_load;
		mas_pkg::mas_pos_t pos_val;
		logic teach_write;
		mas_pkg::mas_teach_s teach;
	} mas_main_st_s;

	mas_main_st_s q;
	mas_main_st_s d;
	mas_pkg::mas_pins_s pins;
	mas_pkg::mas_pins_s rise;
	mas_pkg::mas_prof_s inch_prof;
	mas_pkg::mas_prof_s ret_prof;
	mas_pkg::mas_pos_t inch_tgt_f;
	mas_pkg::mas_pos_t inch_tgt_r;
	logic [22:0] amount;
	logic ot_stop;
	logic fwd_ok;
	logic rev_ok;
	logic alarm_any;
	logic ready_c;
	logic inch_go_f;
	logic inch_go_r;
	logic reexcite;
	logic ret_dir;
	logic ret_go;
	logic preset_go;
	logic org_req;
	logic stop_lvl;

	// Out-of-range settings fall back to their default
	function automatic mas_pkg::mas_rate_t fix_rate(
		input mas_pkg::mas_rate_t v,
		input mas_pkg::mas_rate_t lo,
		input mas_pkg::mas_rate_t def
	);
		return ((v < lo) || (v > mas_pkg::RATE_MAX)) ? def : v;
	endfunction

	mas_sync u_sync (
		.clock(clock),
		.rst(rst),
		.pins_raw(pins_raw),
		.pins_sync(pins)
	);

	mas_ot_check u_ot (
		.hw_ot_en(hw_ot_en),
		.sw_ot_en(sw_ot_en),
		.origin(q.origin),
		.lim_pos(pins.lim_pos),
		.lim_neg(pins.lim_neg),
		.sw_lim_hi(sw_lim_hi),
		.sw_lim_lo(sw_lim_lo),
		.motion(motion),
		.ot_stop(ot_stop),
		.fwd_ok(fwd_ok),
		.rev_ok(rev_ok)
	);

	assign rise = pins & ~q.prev;

	// Zero travel is not a legal amount
	assign amount = (inch_amount < mas_pkg::INCH_AMT_MIN) ? mas_pkg::INCH_AMT_DEF : inch_amount;
	assign inch_prof.speed = fix_rate(inch_cfg.speed, mas_pkg::SPEED_MIN, mas_pkg::SPEED_DEF);
	assign inch_prof.start_speed =
		fix_rate(inch_cfg.start_speed, mas_pkg::START_MIN, mas_pkg::START_DEF);
	assign inch_prof.ramp = fix_rate(inch_cfg.ramp, mas_pkg::RAMP_MIN, mas_pkg::RAMP_DEF);
	assign ret_prof.speed = fix_rate(ret_cfg.speed, mas_pkg::SPEED_MIN, mas_pkg::SPEED_DEF);
	assign ret_prof.start_speed =
		fix_rate(ret_cfg.start_speed, mas_pkg::START_MIN, mas_pkg::START_DEF);
	assign ret_prof.ramp = fix_rate(ret_cfg.ramp, mas_pkg::RAMP_MIN, mas_pkg::RAMP_DEF);

	// Wraps at the 24-bit coordinate edge; software limits should sit inside it
	assign inch_tgt_f = mas_pkg::mas_pos_t'(motion.cmd_pos + $signed({1'b0, amount}));
	assign inch_tgt_r = mas_pkg::mas_pos_t'(motion.cmd_pos - $signed({1'b0, amount}));

	assign alarm_any = q.abs_err || q.org_alarm || other_alarm;
	// Ready only when idle and clear
	assign ready_c = (q.st == mas_pkg::ST_IDLE) && !motion.busy && !alarm_any;

	assign inch_go_f = ready_c && rise.inch_fwd && !pins.inch_rev && fwd_ok;
	assign inch_go_r = ready_c && rise.inch_rev && !pins.inch_fwd && rev_ok;

	assign reexcite = rise.excite || (q.prev.free_run && !pins.free_run) || rise.main_power;
	assign ret_dir = (q.last_pos >= motion.cmd_pos);
	// Armed only after a real stop
	assign ret_go = ready_c && (ret_enable == mas_pkg::FLAG_EN) && q.arm && reexcite &&
		(ret_dir ? fwd_ok : rev_ok);

	// No preset while moving or alarmed
	assign preset_go = ready_c && rise.preset;

	assign org_req = (origin_alarm_en == mas_pkg::FLAG_EN) && !q.origin &&
		(rise.start || rise.seq_start || (|rise.direct_sel));

	assign stop_lvl = pins.stop || stop_cmd;

	always_comb begin
		d = q;
		d.prev = pins;
		d.move_start = 1'b0;
		d.stop_req = 1'b0;
		d.pos_load = 1'b0;
		d.teach_write = 1'b0;
		// Backed-up origin taken after reset release
		if (!q.boot) begin
			d.boot = 1'b1;
			if ((abs_backup_en == mas_pkg::FLAG_EN) && backup_origin_valid) begin
				d.origin = 1'b1;
			end
		end
		if (!motion.busy) begin
			d.stop_sent = 1'b0;
		end else if (!q.stop_sent && (ot_stop || stop_lvl)) begin
			d.stop_sent = 1'b1;
			d.stop_req = 1'b1;
			d.stop_style = ot_stop ? ot_action : stop_action;
		end
		// Remember where the motor last stopped
		if (motion.done) begin
			d.last_pos = motion.cmd_pos;
			d.arm = 1'b1;
		end
		if (config_exec) begin
			d.arm = 1'b0;
		end
		if (motion.done && (motion.kind == mas_pkg::MK_HOME) && !q.abs_err) begin
			d.origin = 1'b1;
		end
		case (q.st)
			mas_pkg::ST_IDLE: begin
				if (inch_go_f || inch_go_r) begin
					d.move_start = 1'b1;
					d.move.dir = inch_go_f;
					d.move.target = inch_go_f ? inch_tgt_f : inch_tgt_r;
					d.move.prof = inch_prof;
					d.move.ramp_unit = ramp_unit;
					d.st = mas_pkg::ST_INCH;
				end else if (ret_go) begin
					d.move_start = 1'b1;
					d.move.dir = ret_dir;
					d.move.target = q.last_pos;
					d.move.prof = ret_prof;
					d.move.ramp_unit = ramp_unit;
					d.st = mas_pkg::ST_RET;
				end else if (preset_go) begin
					d.pos_load = 1'b1;
					d.pos_val = preset_position;
					d.st = mas_pkg::ST_PRESET;
				end else if (teach_req && q.origin) begin
					d.teach_write = 1'b1;
					d.teach.entry = teach_entry;
					d.teach.pos = motion.cmd_pos;
					d.teach.mode_abs = 1'b1;
				end
			end
			mas_pkg::ST_INCH, mas_pkg::ST_RET: begin
				if (motion.done) begin
					d.st = mas_pkg::ST_IDLE;
				end
			end
			mas_pkg::ST_PRESET: begin
				d.origin = 1'b1;
				d.st = mas_pkg::ST_IDLE;
			end
			default: begin
				d.st = mas_pkg::ST_IDLE;
			end
		endcase
		// Position error drops origin; set beats clear
		if (rise.pos_err_clear) begin
			d.abs_err = 1'b0;
		end
		if (abs_pos_err) begin
			d.origin = 1'b0;
			if (abs_backup_en == mas_pkg::FLAG_EN) begin
				d.abs_err = 1'b1;
			end
		end
		if (alarm_clear) begin
			d.org_alarm = 1'b0;
		end
		if (org_req) begin
			d.org_alarm = 1'b1;
		end
		d.block_pos = (origin_alarm_en == mas_pkg::FLAG_EN) && !d.origin;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.st <= mas_pkg::ST_IDLE;
			q.origin <= mas_pkg::ORIGIN_RST;
		end else begin
			q <= d;
		end
	end

	assign ready = ready_c;
	assign move_start = q.move_start;
	assign move = q.move;
	assign stop_req = q.stop_req;
	assign stop_style = q.stop_style;
	assign pos_load = q.pos_load;
	assign pos_load_value = q.pos_val;
	assign origin_done = q.origin;
	assign origin_alarm = q.org_alarm;
	assign abs_err_alarm = q.abs_err;
	assign block_positioning = q.block_pos;
	assign teach_write = q.teach_write;
	assign teach = q.teach;

	a_inch_fwd_go: assert property (@(posedge clock) disable iff (rst)
		inch_go_f |=> move_start && move.dir && (move.target == $past(inch_tgt_f)))
		else $error("forward inch not issued as a positive move");

	a_ready_drop: assert property (@(posedge clock) disable iff (rst)
		move_start |-> !ready ##1 (!ready || (q.st == mas_pkg::ST_IDLE)))
		else $error("ready high while a move starts");

	a_both_inch: assert property (@(posedge clock) disable iff (rst)
		(pins.inch_fwd && pins.inch_rev) |=> !(move_start && (q.st == mas_pkg::ST_INCH)))
		else $error("inch move started with both inch inputs");

	a_stop_style: assert property (@(posedge clock) disable iff (rst)
		(motion.busy && stop_lvl && !ot_stop && !q.stop_sent)
		|=> stop_req && (stop_style == $past(stop_action)))
		else $error("stop request missing or wrong style");

	a_ot_style: assert property (@(posedge clock) disable iff (rst)
		(ot_stop && !q.stop_sent) |=> stop_req && (stop_style == $past(ot_action)))
		else $error("overtravel stop missing or wrong style");

	a_preset_order: assert property (@(posedge clock) disable iff (rst)
		pos_load |-> $past(ready_c) ##1 (origin_done || $past(abs_pos_err)))
		else $error("preset did not raise origin-done");

	a_origin_alarm: assert property (@(posedge clock) disable iff (rst)
		org_req |=> origin_alarm && block_positioning)
		else $error("incomplete-origin alarm not raised");

	a_abs_err_loss: assert property (@(posedge clock) disable iff (rst)
		abs_pos_err |=> !origin_done)
		else $error("origin kept across position error");

	a_cfg_disarm: assert property (@(posedge clock) disable iff (rst)
		(config_exec && !motion.done) |=> !ret_go)
		else $error("return armed right after configuration");

	a_teach_abs: assert property (@(posedge clock) disable iff (rst)
		teach_write |-> teach.mode_abs && $past(q.origin) && (teach.pos == $past(motion.cmd_pos)))
		else $error("teach capture without origin or not absolute");
endmodule

// >>> mas_engine_model.sv
/*
 Behavioural profile engine facing the supervisor: runs each move for a set
 number of cycles, obeys stop pulses and loads preset positions.
 Assumes the bench chooses motion kind and run length before each move.
*/
`timescale 1ns/10ps
module mas_engine_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic move_start,
	input wire mas_pkg::mas_move_s move,
	input wire logic stop_req,
	input wire logic pos_load,
	input wire mas_pkg::mas_pos_t pos_load_value,
	input wire mas_pkg::mas_kind_e kind,
	input wire logic [7:0] run_len,
	input wire logic nudge,
	output mas_pkg::mas_motion_s motion
);
	logic [7:0] cnt_q;
	mas_pkg::mas_pos_t tgt_q;

	always_ff @(posedge clock) begin
		motion.done <= 1'b0;
		if (rst) begin
			motion <= '0;
			cnt_q <= 8'h00;
			tgt_q <= '0;
		end else if (motion.busy) begin
			cnt_q <= cnt_q - 8'h01;
			// A stopped move keeps its start position, never the target
			if (stop_req || cnt_q == 8'h00) begin
				motion.busy <= 1'b0;
				motion.done <= 1'b1;
				if (!stop_req) begin
					motion.cmd_pos <= tgt_q;
				end
			end
		end else if (move_start) begin
			motion.busy <= 1'b1;
			motion.dir <= move.dir;
			motion.kind <= kind;
			tgt_q <= move.target;
			cnt_q <= run_len;
		end else if (pos_load) begin
			motion.cmd_pos <= pos_load_value;
		end else if (nudge) begin
			// External force shifts the idle shaft
			motion.cmd_pos <= motion.cmd_pos + 24'h000005;
		end
	end
endmodule

// >>> testbench.sv
/*
 Self-checking bench of the motion supervisor with a behavioural engine.
 Assumes one 10 MHz clock and settings driven as plain ports.
*/
`timescale 1ns/10ps
`define CK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t got %0h want %0h", $time, g, e); end end
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	mas_pkg::mas_pins_s pins_raw = '0;
	logic stop_cmd = 1'b0, config_exec = 1'b0, ramp_unit = 1'b1, ret_enable = 1'b0;
	logic [22:0] inch_amount = 23'h000005;
	mas_pkg::mas_prof_s inch_cfg = {20'h007d0, 20'h00064, 20'h00032};
	mas_pkg::mas_prof_s ret_cfg = {20'h00bb8, 20'h000c8, 20'h0012c};
	mas_pkg::mas_stop_e stop_action = mas_pkg::STOP_DECEL, ot_action = mas_pkg::STOP_IMMED;
	logic hw_ot_en = 1'b0, sw_ot_en = 1'b1, abs_backup_en = 1'b0, backup_origin_valid = 1'b0;
	mas_pkg::mas_pos_t sw_lim_hi = '0, sw_lim_lo = 24'hfffc18, preset_position = 24'h00000a;
	logic origin_alarm_en = 1'b0, abs_pos_err = 1'b0, alarm_clear = 1'b0, other_alarm = 1'b0;
	logic teach_req = 1'b0, nudge = 1'b0;
	logic [5:0] teach_entry = 6'h00;
	mas_pkg::mas_kind_e kind = mas_pkg::MK_POSN;
	logic [7:0] run_len = 8'h06;
	mas_pkg::mas_motion_s motion;
	logic ready, move_start, stop_req, pos_load, origin_done, origin_alarm;
	logic abs_err_alarm, block_positioning, teach_write;
	mas_pkg::mas_move_s move;
	mas_pkg::mas_stop_e stop_style;
	mas_pkg::mas_pos_t pos_load_value;
	mas_pkg::mas_teach_s teach;
	int error_cnt = 0, checked = 0, n_ms = 0, n_sr = 0, n_pl = 0, n_tw = 0, cyc_cnt = 0;

	mas_supervisor mas_supervisor_i (.clock, .rst, .pins_raw, .stop_cmd, .config_exec,
		.inch_amount, .inch_cfg, .ret_cfg, .ramp_unit, .ret_enable, .stop_action, .ot_action,
		.hw_ot_en, .sw_ot_en, .sw_lim_hi, .sw_lim_lo, .abs_backup_en, .backup_origin_valid,
		.origin_alarm_en, .preset_position, .abs_pos_err, .alarm_clear, .other_alarm, .motion,
		.teach_req, .teach_entry, .ready, .move_start, .move, .stop_req, .stop_style, .pos_load,
		.pos_load_value, .origin_done, .origin_alarm, .abs_err_alarm, .block_positioning,
		.teach_write, .teach);
	mas_engine_model mas_engine_model_i (.clock, .rst, .move_start, .move, .stop_req,
		.pos_load, .pos_load_value, .kind, .run_len, .nudge, .motion);

	always #50 clock = ~clock;

	// Pulse outputs stand one cycle, so they are counted rather than polled
	always @(posedge clock) begin
		n_ms += move_start;
		n_sr += stop_req;
		n_pl += pos_load;
		n_tw += teach_write;
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			results();
		end
	end

	task results;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic await(ref int c, input int base, output bit hit);
		hit = 1'b0;
		for (int i = 0; i < 12 && !hit; i++) begin
			cyc(1);
			hit = (c != base);
		end
	endtask

	task automatic inch(input bit fwd, output bit hit);
		int base;
		base = n_ms;
		@(posedge clock);
		pins_raw.inch_fwd <= fwd;
		pins_raw.inch_rev <= !fwd;
		await(n_ms, base, hit);
		@(posedge clock);
		pins_raw.inch_fwd <= 1'b0;
		pins_raw.inch_rev <= 1'b0;
	endtask

	task idle;
		for (int i = 0; i < 200 && ready !== 1'b1; i++)
			cyc(1);
		cyc(2);
	endtask

	task automatic t_inch;
		bit hit;
		inch(1'b1, hit);
		`CK(hit, 1'b1);
		`CK(ready, 1'b0);
		`CK(move.dir, 1'b1);
		`CK(move.target, 24'h000005);
		`CK(move.prof, inch_cfg);
		`CK(move.ramp_unit, 1'b1);
		idle();
		`CK(ready, 1'b1);
	endtask

	task automatic t_defaults;
		bit hit;
		@(posedge clock);
		inch_amount <= 23'h000000;
		inch_cfg <= {20'h00000, 20'hfffff, 20'h00000};
		ramp_unit <= 1'b0;
		inch(1'b0, hit);
		`CK(hit, 1'b1);
		`CK(move.dir, 1'b0);
		`CK(move.target, 24'h000004);
		`CK(move.prof.speed, mas_pkg::SPEED_DEF);
		`CK(move.prof.start_speed, mas_pkg::START_DEF);
		`CK(move.prof.ramp, mas_pkg::RAMP_DEF);
		`CK(move.ramp_unit, 1'b0);
		idle();
		@(posedge clock);
		inch_amount <= 23'h000001;
		inch_cfg <= {20'h007d0, 20'h00000, 20'h00032};
	endtask

	task t_both;
		int base;
		base = n_ms;
		@(posedge clock);
		pins_raw.inch_fwd <= 1'b1;
		pins_raw.inch_rev <= 1'b1;
		cyc(8);
		`CK(n_ms, base);
		@(posedge clock);
		pins_raw.inch_fwd <= 1'b0;
		pins_raw.inch_rev <= 1'b0;
		cyc(4);
	endtask

	task automatic t_stop;
		bit hit;
		int base;
		@(posedge clock);
		run_len <= 8'h3c;
		for (int i = 0; i < 2; i++) begin
			inch(1'b1, hit);
			base = n_sr;
			pins_raw.stop <= (i == 0);
			stop_cmd <= (i == 1);
			await(n_sr, base, hit);
			`CK(hit, 1'b1);
			`CK(stop_style, mas_pkg::STOP_DECEL);
			@(posedge clock);
			pins_raw.stop <= 1'b0;
			stop_cmd <= 1'b0;
			idle();
		end
		@(posedge clock);
		run_len <= 8'h06;
	endtask

	task automatic t_hw;
		bit hit;
		int base;
		@(posedge clock);
		hw_ot_en <= 1'b1;
		kind <= mas_pkg::MK_CONT;
		run_len <= 8'h3c;
		// Continuous move leaves the positive sensor
		inch(1'b0, hit);
		`CK(hit, 1'b1);
		base = n_sr;
		pins_raw.lim_pos <= 1'b1;
		cyc(8);
		`CK(n_sr, base);
		idle();
		inch(1'b1, hit);
		`CK(hit, 1'b0);
		// A continuous move may not start off a sensor in either direction
		inch(1'b0, hit);
		`CK(hit, 1'b0);
		@(posedge clock);
		pins_raw.lim_pos <= 1'b0;
		kind <= mas_pkg::MK_POSN;
		repeat (3) @(posedge clock);
		inch(1'b0, hit);
		base = n_sr;
		pins_raw.lim_pos <= 1'b1;
		await(n_sr, base, hit);
		`CK(hit, 1'b1);
		`CK(stop_style, mas_pkg::STOP_IMMED);
		idle();
		@(posedge clock);
		pins_raw.lim_pos <= 1'b0;
		run_len <= 8'h06;
		cyc(3);
	endtask

	task automatic t_preset;
		bit hit;
		int base;
		base = n_pl;
		@(posedge clock);
		other_alarm <= 1'b1;
		pins_raw.preset <= 1'b1;
		cyc(6);
		`CK(n_pl, base);
		`CK(origin_done, 1'b0);
		@(posedge clock);
		pins_raw.preset <= 1'b0;
		other_alarm <= 1'b0;
		repeat (3) @(posedge clock);
		pins_raw.preset <= 1'b1;
		await(n_pl, base, hit);
		`CK(hit, 1'b1);
		`CK(pos_load_value, 24'h00000a);
		cyc(1);
		`CK(origin_done, 1'b1);
		@(posedge clock);
		pins_raw.preset <= 1'b0;
		cyc(3);
	endtask

	task automatic t_sw_teach;
		bit hit;
		int base;
		inch(1'b1, hit);
		`CK(hit, 1'b0);
		sw_ot_en <= 1'b0;
		base = n_tw;
		teach_req <= 1'b1;
		teach_entry <= 6'h2a;
		@(posedge clock);
		teach_req <= 1'b0;
		await(n_tw, base, hit);
		`CK(hit, 1'b1);
		`CK(teach.entry, 6'h2a);
		`CK(teach.pos, 24'h00000a);
		`CK(teach.mode_abs, 1'b1);
	endtask

	task nudge_shaft;
		@(posedge clock);
		nudge <= 1'b1;
		@(posedge clock);
		nudge <= 1'b0;
	endtask

	task automatic t_return;
		bit hit;
		int base;
		@(posedge clock);
		ret_enable <= 1'b1;
		inch(1'b1, hit);
		idle();
		nudge_shaft();
		base = n_ms;
		pins_raw.excite <= 1'b1;
		await(n_ms, base, hit);
		`CK(hit, 1'b1);
		`CK(move.target, 24'h00000b);
		`CK(move.dir, 1'b0);
		`CK(move.prof, ret_cfg);
		idle();
		@(posedge clock);
		config_exec <= 1'b1;
		nudge <= 1'b1;
		pins_raw.excite <= 1'b0;
		@(posedge clock);
		config_exec <= 1'b0;
		nudge <= 1'b0;
		repeat (4) @(posedge clock);
		base = n_ms;
		pins_raw.excite <= 1'b1;
		cyc(8);
		`CK(n_ms, base);
		// Free-run release and power-up re-excite too
		inch(1'b1, hit);
		idle();
		nudge_shaft();
		pins_raw.free_run <= 1'b1;
		repeat (4) @(posedge clock);
		base = n_ms;
		pins_raw.free_run <= 1'b0;
		await(n_ms, base, hit);
		`CK(hit, 1'b1);
		`CK(move.target, 24'h000011);
		idle();
		nudge_shaft();
		base = n_ms;
		pins_raw.main_power <= 1'b1;
		await(n_ms, base, hit);
		`CK(hit, 1'b1);
		`CK(move.target, 24'h000011);
		idle();
	endtask

	task automatic t_abs_alarm;
		bit hit;
		int base;
		@(posedge clock);
		abs_backup_en <= 1'b1;
		abs_pos_err <= 1'b1;
		@(posedge clock);
		abs_pos_err <= 1'b0;
		cyc(3);
		`CK(origin_done, 1'b0);
		`CK(abs_err_alarm, 1'b1);
		`CK(ready, 1'b0);
		@(posedge clock);
		pins_raw.pos_err_clear <= 1'b1;
		cyc(5);
		`CK(abs_err_alarm, 1'b0);
		@(posedge clock);
		pins_raw.pos_err_clear <= 1'b0;
		origin_alarm_en <= 1'b1;
		cyc(3);
		`CK(block_positioning, 1'b1);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			pins_raw.start <= (i == 0);
			pins_raw.seq_start <= (i == 1);
			pins_raw.direct_sel <= (i > 1) ? (6'h01 << (i - 2)) : 6'h00;
			cyc(5);
			`CK(origin_alarm, 1'b1);
			`CK(ready, 1'b0);
			@(posedge clock);
			pins_raw.start <= 1'b0;
			pins_raw.seq_start <= 1'b0;
			pins_raw.direct_sel <= 6'h00;
			alarm_clear <= 1'b1;
			@(posedge clock);
			alarm_clear <= 1'b0;
			cyc(3);
			`CK(origin_alarm, 1'b0);
		end
		@(posedge clock);
		kind <= mas_pkg::MK_HOME;
		inch(1'b1, hit);
		idle();
		`CK(origin_done, 1'b1);
		`CK(block_positioning, 1'b0);
		// Backed-up origin survives a mid-run reset
		@(posedge clock);
		kind <= mas_pkg::MK_POSN;
		backup_origin_valid <= 1'b1;
		rst <= 1'b1;
		base = n_ms;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		cyc(3);
		`CK(origin_done, 1'b1);
		`CK(origin_alarm, 1'b0);
		`CK(ready, 1'b1);
		cyc(6);
		`CK(n_ms, base);
	endtask

	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		cyc(3);
		`CK(block_positioning, 1'b0);
		`CK(origin_done, 1'b0);
		`CK(ready, 1'b1);
		t_inch();
		t_defaults();
		t_both();
		t_stop();
		t_hw();
		t_preset();
		t_sw_teach();
		t_return();
		t_abs_alarm();
		results();
	end
endmodule
